// file: hdl/pcc_clock_control.sv
// Core clock control: divider select, lock status, strap and fast irq.
// Operation
// - PLL runs at 384 times crystal, 12.582912 MHz system rate.
// - Reset default core rate is PLL divided by eight.
// - ADC modulator tick equals crystal rate; other ADC ticks from PLL.
// - Divider field bits 2:0 select PLL rate over two to the field.
// - Bit 7 stops crystal only in power-down; normal mode keeps it.
// - With bit 7 clear, seconds counter runs and wakes CPU.
// - Bit 6 reads one while PLL tracks crystal, else zero.
// - Bit 4 returns external access pin latched at reset.
// - Bit 3 set services interrupts at fastest core rate.
// - Low-voltage parts ignore whole writes selecting divider zero.
// - Fast response forces divider zero; not for low-voltage parts (the LOW_VOLTAGE build still honours bit 3 and forces it).
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defs.svh"
module pcc_clock_control
  import pcc_pkg::*;
#(
  parameter bit LOW_VOLTAGE = 1'b0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [7:0] rdata,
  input wire logic pll_tick,
  input wire logic xtal_tick,
  input wire logic powerdown_mode,
  input wire logic irq_active,
  input wire logic external_access_pin,
  output logic core_clk_en,
  output logic adc_mod_en,
  output logic adc_clk_en,
  output logic xtal_osc_enable,
  output logic seconds_pulse,
  output logic wake_request,
  output logic irq
);
  logic [7:0] ctrl_reg;
  logic strap_reg;
  logic strap_taken_reg;
  logic [`PCC_IRQ_BITS-1:0] status_reg;
  logic [`PCC_IRQ_BITS-1:0] mask_reg;
  logic [7:0] rdata_reg;
  logic lock_prev_reg;
  logic [14:0] sec_cnt_reg;
  logic locked;
  logic core_div_en;
  logic [2:0] eff_div;
  logic [`PCC_IRQ_BITS-1:0] events;

  wire sel_ctrl = (addr == `PCC_ADDR_CONTROL);
  wire sel_status = (addr == `PCC_ADDR_IRQ_STATUS);
  wire sel_mask = (addr == `PCC_ADDR_IRQ_MASK);
  wire [2:0] wr_div = wdata[`PCC_DIV_MSB:0];
  wire wr_refused = LOW_VOLTAGE && (wr_div == `PCC_DIV_FULL);
  wire ctrl_we = wr_en && sel_ctrl && !wr_refused;
  wire fast_irq_clock = ctrl_reg[`PCC_BIT_FAST_IRQ];
  wire crystal_osc_powerdown = ctrl_reg[`PCC_BIT_CRYSTAL_OSC_POWERDOWN];
  wire [2:0] core_clock_divider = ctrl_reg[`PCC_DIV_MSB:0];

  assign xtal_osc_enable = !(powerdown_mode && crystal_osc_powerdown);
  wire xtal_run = xtal_tick && xtal_osc_enable;

  assign eff_div = (fast_irq_clock && irq_active) ? `PCC_DIV_FULL :
                   core_clock_divider;

  pcc_divider u_core_div (
    .clk(clk),
    .rst(rst),
    .en_in(pll_tick),
    .sel(eff_div),
    .en_out(core_div_en)
  );
  assign core_clk_en = core_div_en && !powerdown_mode;

  assign adc_mod_en = xtal_run;
  assign adc_clk_en = pll_tick;

  pcc_lock_detect u_lock (
    .clk(clk),
    .rst(rst),
    .ref_ok(xtal_osc_enable),
    .locked(locked)
  );

  wire sec_wrap = xtal_run && (sec_cnt_reg == 15'h7FFF);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sec_cnt_reg <= 15'h0000;
    end else if (xtal_run) begin
      sec_cnt_reg <= 15'(sec_cnt_reg + 15'h0001);
    end
  end
  assign seconds_pulse = sec_wrap;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_prev_reg <= 1'b0;
    end else begin
      lock_prev_reg <= locked;
    end
  end
  assign events[`PCC_IRQ_LOCK_GAIN] = locked && !lock_prev_reg;
  assign events[`PCC_IRQ_LOCK_LOSS] = !locked && lock_prev_reg;
  assign events[`PCC_IRQ_SECONDS] = sec_wrap;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= `PCC_CONTROL_RESET;
    end else if (ctrl_we) begin
      ctrl_reg <= wdata & `PCC_WRITE_MASK;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      strap_taken_reg <= 1'b0;
      strap_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_reg <= external_access_pin;
    end
  end

  wire [`PCC_IRQ_BITS-1:0] status_clr =
    (wr_en && sel_status) ? wdata[`PCC_IRQ_BITS-1:0] : '0;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_reg <= '0;
      mask_reg <= '0;
    end else begin
      status_reg <= (status_reg & ~status_clr) | events;
      if (wr_en && sel_mask) begin
        mask_reg <= wdata[`PCC_IRQ_BITS-1:0];
      end
    end
  end
  assign irq = |(status_reg & mask_reg);
  assign wake_request = powerdown_mode && !crystal_osc_powerdown &&
                        status_reg[`PCC_IRQ_SECONDS] &&
                        mask_reg[`PCC_IRQ_SECONDS];

  wire [7:0] ctrl_view = {ctrl_reg[7], locked, 1'b0, strap_reg,
                          ctrl_reg[3:0]};
  wire [7:0] rd_mux = sel_ctrl ? ctrl_view :
                      sel_status ? {5'h00, status_reg} :
                      sel_mask ? {5'h00, mask_reg} : 8'h00;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else if (rd_en) begin
      rdata_reg <= rd_mux;
    end else begin
      rdata_reg <= 8'h00;
    end
  end
  assign rdata = rdata_reg;

  a_refuse_keep: assert property (@(posedge clk) disable iff (rst)
    (LOW_VOLTAGE && wr_en && sel_ctrl && wdata[2:0] == 3'h0)
    |=> $stable(ctrl_reg))
    else $error("refused divider write changed control");
  a_osc_gate: assert property (@(posedge clk) disable iff (rst)
    !powerdown_mode |-> xtal_osc_enable)
    else $error("oscillator stopped in normal mode");
  a_fast_div: assert property (@(posedge clk) disable iff (rst)
    (fast_irq_clock && irq_active && pll_tick) |-> core_div_en)
    else $error("fast irq not at full rate");
  a_strap_hold: assert property (@(posedge clk) disable iff (rst)
    strap_taken_reg |=> $stable(strap_reg))
    else $error("strap changed after capture");
  a_div_full: assert property (@(posedge clk) disable iff (rst)
    (eff_div == 3'h0 && pll_tick) |-> core_div_en)
    else $error("divider zero missed a tick");
  a_lock_drop: assert property (@(posedge clk) disable iff (rst)
    !xtal_osc_enable |=> !locked)
    else $error("lock held without reference");
  a_adc_mod: assert property (@(posedge clk) disable iff (rst)
    adc_mod_en |-> xtal_tick)
    else $error("modulator tick without crystal");
  a_read_zero: assert property (@(posedge clk) disable iff (rst)
    !rd_en |=> rdata == 8'h00)
    else $error("read data outside read cycle");
endmodule
`default_nettype wire

// file: hdl/pcc_defs.svh
// Register map, field positions, reset values and timing counts.
`ifndef PCC_DEFS_SVH
`define PCC_DEFS_SVH
`define PCC_ADDR_CONTROL 8'hD7
`define PCC_ADDR_IRQ_STATUS 8'hD8
`define PCC_ADDR_IRQ_MASK 8'hD9
`define PCC_CONTROL_RESET 8'h53
`define PCC_BIT_CRYSTAL_OSC_POWERDOWN 7
`define PCC_BIT_LOCK 6
`define PCC_BIT_STRAP 4
`define PCC_BIT_FAST_IRQ 3
`define PCC_DIV_MSB 2
`define PCC_WRITE_MASK 8'h8F
`define PCC_PLL_MULT 384
`define PCC_PLL_HZ 12582912
`define PCC_XTAL_HZ 32768
`define PCC_DIV_FULL 3'h0
`define PCC_IRQ_LOCK_GAIN 0
`define PCC_IRQ_LOCK_LOSS 1
`define PCC_IRQ_SECONDS 2
`define PCC_IRQ_BITS 3
`define PCC_LOCK_CYCLES 16'h0040
`endif

// file: hdl/pcc_pkg.sv
// Types shared by the clock control design.
package pcc_pkg;
  typedef enum logic [1:0] {
    PCC_UNLOCKED,
    PCC_ACQUIRE,
    PCC_LOCKED
  } pcc_lock_state_t;
endpackage

// file: hdl/pcc_divider.sv
// Binary enable divider: one-cycle pulse every 2**sel input enables.
`timescale 1ns/1ps
`default_nettype none
module pcc_divider (
  input wire logic clk,
  input wire logic rst,
  input wire logic en_in,
  input wire logic [2:0] sel,
  output logic en_out
);
  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  wire [6:0] span = 7'((8'h01 << sel) - 8'h01);
  wire at_end = (cnt_reg >= span);
  assign cnt_next = at_end ? 7'h00 : 7'(cnt_reg + 7'h01);
  assign en_out = en_in && at_end;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cnt_reg <= 7'h00;
    end else if (en_in) begin
      cnt_reg <= cnt_next;
    end
  end
endmodule
`default_nettype wire

// file: hdl/pcc_lock_detect.sv
// Lock tracker: counts clock cycles while the crystal oscillator is enabled.
`timescale 1ns/1ps
`default_nettype none
`include "pcc_defs.svh"
module pcc_lock_detect
  import pcc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic ref_ok,
  output logic locked
);
  pcc_lock_state_t state_reg;
  logic [15:0] cnt_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= PCC_UNLOCKED;
      cnt_reg <= 16'h0000;
    end else if (!ref_ok) begin
      state_reg <= PCC_UNLOCKED;
      cnt_reg <= 16'h0000;
    end else begin
      unique case (state_reg)
        PCC_UNLOCKED: state_reg <= PCC_ACQUIRE;
        PCC_ACQUIRE: begin
          cnt_reg <= 16'(cnt_reg + 16'h0001);
          if (cnt_reg == `PCC_LOCK_CYCLES) begin
            state_reg <= PCC_LOCKED;
          end
        end
        PCC_LOCKED: state_reg <= PCC_LOCKED;
        default: state_reg <= PCC_UNLOCKED;
      endcase
    end
  end
  assign locked = (state_reg == PCC_LOCKED);
endmodule
`default_nettype wire

// file: verification/pcc_xtal_model.sv
// Crystal and PLL reference tick source for the clock control block.
`timescale 1ns/1ps
`default_nettype none
module pcc_xtal_model #(
  parameter int PLL_DIV = 2,
  parameter int MULT = 384
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic osc_en,
  output logic pll_tick,
  output logic xtal_tick
);
  int pc;
  int xc;
  assign pll_tick = (pc == PLL_DIV - 1);
  assign xtal_tick = pll_tick && osc_en && (xc == MULT - 1);
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc <= 0;
      xc <= 0;
    end else begin
      pc <= pll_tick ? 0 : pc + 1;
      if (pll_tick && osc_en)
        xc <= (xc == MULT - 1) ? 0 : xc + 1;
    end
  end
endmodule
`default_nettype wire

// file: verification/pcc_clock_control_tb.sv
// Self-checking bench for the core clock control block.
`timescale 1ns/1ps
`default_nettype none
module pcc_clock_control_tb;
  logic clk = 0, rst = 1, wr_en = 0, wr_lv = 0, rd_en = 0, pd = 0;
  logic irq_act = 0, ea = 1;
  wire logic wake;
  logic [7:0] addr = 0, wdata = 0, last;
  wire logic [7:0] rdata, rdata_lv;
  wire logic pll_tick, xtal_tick, core_en, mod_en, adc_en, osc_en, irq;
  int mismatches = 0, n_checks = 0, n;
  always #5 clk = ~clk;
  pcc_xtal_model xm (.clk(clk), .rst(rst), .osc_en(osc_en),
    .pll_tick(pll_tick), .xtal_tick(xtal_tick));
  pcc_clock_control dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .pll_tick(pll_tick),
    .xtal_tick(xtal_tick), .powerdown_mode(pd), .irq_active(irq_act),
    .external_access_pin(ea), .core_clk_en(core_en), .adc_mod_en(mod_en),
    .adc_clk_en(adc_en), .xtal_osc_enable(osc_en), .seconds_pulse(),
    .wake_request(wake), .irq(irq));
  pcc_clock_control #(.LOW_VOLTAGE(1'b1)) dut_lv (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr_en(wr_lv), .rd_en(rd_en),
    .rdata(rdata_lv), .pll_tick(pll_tick), .xtal_tick(xtal_tick),
    .powerdown_mode(pd), .irq_active(irq_act), .external_access_pin(ea),
    .core_clk_en(), .adc_mod_en(), .adc_clk_en(), .xtal_osc_enable(),
    .seconds_pulse(), .wake_request(), .irq());
  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, logic l = 0);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    if (l) wr_lv <= 1;
    else wr_en <= 1;
    @(posedge clk);
    wr_en <= 0;
    wr_lv <= 0;
  endtask
  task automatic rdv(logic [7:0] a, logic l);
    @(posedge clk);
    addr <= a;
    rd_en <= 1;
    @(posedge clk);
    rd_en <= 0;
    @(negedge clk);
    last = l ? rdata_lv : rdata;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, logic l = 0);
    rdv(a, l);
    chk("rdata", last, e);
  endtask
  task automatic wt;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!core_en && n < 600);
    if (n >= 600) begin
      mismatches++;
      conclude();
    end
  endtask
  task automatic per(int e);
    repeat (3) wt();
    chk("period", n[15:0], e[15:0]);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    rst <= 0;
    rd(8'hD7, 8'h13);
    ea <= 0;
    repeat (80) @(posedge clk);
    rd(8'hD7, 8'h53);
    rd(8'hD8, 8'h01);
    rd(8'hD0, 8'h00);
    chk("irq", irq, 0);
    wr(8'hD9, 8'h01);
    @(negedge clk);
    chk("irq", irq, 1);
    wr(8'hD8, 8'h01);
    rd(8'hD8, 8'h00);
    chk("irq", irq, 0);
    $display("register test done");
    per(16);
    for (int d = 0; d < 8; d++) begin
      wr(8'hD7, d[7:0]);
      rd(8'hD7, 8'h50 | d[7:0]);
      per(2 << d);
    end
    repeat (4) begin
      @(negedge clk);
      chk("adc", {adc_en, mod_en}, {pll_tick, xtal_tick});
    end
    wr(8'hD7, 8'h0B);
    irq_act <= 1;
    per(2);
    @(posedge clk);
    irq_act <= 0;
    per(16);
    $display("divider test done");
    wr(8'hD7, 8'h00, 1);
    rd(8'hD7, 8'h53, 1);
    wr(8'hD7, 8'h01, 1);
    rd(8'hD7, 8'h51, 1);
    wr(8'hD7, 8'h80, 1);
    rd(8'hD7, 8'h51, 1);
    $display("low voltage test done");
    wr(8'hD7, 8'h83);
    chk("osc", osc_en, 1);
    pd <= 1;
    @(negedge clk);
    chk("osc", osc_en, 0);
    rd(8'hD7, 8'h93);
    rd(8'hD8, 8'h02);
    @(posedge clk);
    pd <= 0;
    n = 0;
    do begin
      rdv(8'hD7, 0);
      n++;
    end while (!last[6] && n < 200);
    chk("lock", last, 8'hD3);
    chk("irq", irq, 1);
    wr(8'hD7, 8'h03);
    pd <= 1;
    @(negedge clk);
    chk("osc", osc_en, 1);
    chk("wake", wake, 0);
    @(posedge clk);
    pd <= 0;
    $display("power-down test done");
    conclude();
  end
endmodule
`default_nettype wire
